// file: design/parallel_strap_config.sv
// configuration register file loaded from strap pins until serial control takes over
// What this block does
// - Strap values load into the registers once, on the first edge after reset unless a serial write arrives on that edge, and later strap changes are ignored.
// - The enable strap turns the high-speed channels on at 1 and into standby at 0.
// - The two select straps route high-speed source A, B, C or D for codes 00 to 11.
// - The same select straps route auxiliary source A, B, C or D to the common port.
// - Input terminations stay disconnected under straps; only a serial write connects them.
// - Both input termination registers load as all zeros under straps.
// - The equalization strap is copied into all sixteen equalizer bits.
// - High-speed modes holds enable in bit 6, zeros in 5..2 and select in 1..0.
// - Auxiliary modes holds a forced 1 in bit 6, zeros in 5..2 and select in 1..0.
// - Transmitter settings holds pre-emphasis in 3..2, output termination in 1, current in 0.
// - The equalization strap selects 6 dB at 0 and 12 dB at 1.
// - Pre-emphasis codes 00 to 11 select 0, 2, 4 or 6 dB.
// - The output-termination strap turns all output terminations off at 0 and on at 1.
// - The output-current strap selects 10 mA at 0 and 20 mA at 1.
`timescale 1ns/10ps
`include "strap_cfg.svh"
module parallel_strap_config
    import strap_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic STRAP_HIGHSPEED_ENABLE,
    input wire logic [1:0] STRAP_SOURCE_SELECT,
    input wire logic STRAP_EQUALIZATION_LEVEL,
    input wire logic [1:0] STRAP_PREEMPHASIS_LEVEL,
    input wire logic STRAP_OUTPUT_TERMINATION,
    input wire logic STRAP_OUTPUT_CURRENT,
    input wire logic SERIAL_WRITE,
    input wire logic SERIAL_READ,
    input wire logic [2:0] SERIAL_ADDR,
    input wire logic [7:0] SERIAL_WDATA,
    output logic [7:0] SERIAL_RDATA,
    output logic SERIAL_OWNED,
    output logic HIGHSPEED_ON,
    output logic [1:0] HIGHSPEED_SOURCE,
    output logic AUX_ON,
    output logic [1:0] AUX_COMMON_PORT_SOURCE,
    output logic [15:0] INPUT_TERM_CONNECT,
    output logic [15:0] EQUALIZER_HIGH,
    output logic [1:0] PREEMPHASIS_LEVEL,
    output logic OUTPUT_TERM_ON,
    output logic OUTPUT_CURRENT_HIGH
);
    strap_if straps ();

    owner_e owner_q;
    reg8_t high_speed_modes_q;
    reg8_t auxiliary_modes_q;
    reg8_t receiver_settings_q;
    reg8_t input_termination_ab_q;
    reg8_t input_termination_cd_q;
    reg8_t equalizer_ab_q;
    reg8_t equalizer_cd_q;
    reg8_t transmitter_settings_q;
    logic serial_access;

    function automatic reg8_t modes_word(input logic enable, input logic [1:0] sel);
        reg8_t w;
        w = `REG_RESET_VALUE;
        w[`MODES_ENABLE_BIT] = enable;
        w[`MODES_SELECT_LSB +: 2] = sel;
        return w;
    endfunction

    strap_sync sync_u (
        .clk(CORE_CLK),
        .pins({STRAP_OUTPUT_CURRENT, STRAP_OUTPUT_TERMINATION, STRAP_PREEMPHASIS_LEVEL,
               STRAP_EQUALIZATION_LEVEL, STRAP_SOURCE_SELECT, STRAP_HIGHSPEED_ENABLE}),
        .straps(straps)
    );

    assign serial_access = SERIAL_WRITE | SERIAL_READ;

    // ownership: reset -> parallel (one load edge) -> serial on first access
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            owner_q <= ST_RESET;
        end else begin
            case (owner_q)
                ST_RESET: begin
                    owner_q <= serial_access ? ST_SERIAL : ST_PARALLEL;
                end
                ST_PARALLEL: begin
                    if (serial_access) begin
                        owner_q <= ST_SERIAL;
                    end
                end
                default: begin
                    owner_q <= ST_SERIAL;
                end
            endcase
        end
    end

    // straps loaded once on the edge after reset release unless SERIAL_WRITE is high then; a board that moves the select pins must reset
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            high_speed_modes_q <= `REG_RESET_VALUE;
            auxiliary_modes_q <= `REG_RESET_VALUE;
            receiver_settings_q <= `REG_RESET_VALUE;
            input_termination_ab_q <= `REG_RESET_VALUE;
            input_termination_cd_q <= `REG_RESET_VALUE;
            equalizer_ab_q <= `REG_RESET_VALUE;
            equalizer_cd_q <= `REG_RESET_VALUE;
            transmitter_settings_q <= `REG_RESET_VALUE;
        end else if (owner_q == ST_RESET && !SERIAL_WRITE) begin
            // single load after release; later strap motion ignored
            high_speed_modes_q <= modes_word(straps.highspeed_enable,
                                             straps.source_select);
            auxiliary_modes_q <= modes_word(`AUX_ENABLE_VALUE,
                                            straps.source_select);
            receiver_settings_q <= `RX_PARALLEL_VALUE;
            input_termination_ab_q <= `TERM_PARALLEL_VALUE;
            input_termination_cd_q <= `TERM_PARALLEL_VALUE;
            equalizer_ab_q <= {8{straps.equalization_level}};
            equalizer_cd_q <= {8{straps.equalization_level}};
            transmitter_settings_q <= {4'h0, straps.preemphasis_level,
                                       straps.output_termination,
                                       straps.output_current};
        end else if (SERIAL_WRITE) begin
            // only serial writes load nonzero values into the termination registers
            if (SERIAL_ADDR == `ADDR_HIGH_SPEED_MODES) begin
                high_speed_modes_q <= SERIAL_WDATA;
            end else if (SERIAL_ADDR == `ADDR_AUXILIARY_MODES) begin
                auxiliary_modes_q <= SERIAL_WDATA;
            end else if (SERIAL_ADDR == `ADDR_RECEIVER_SETTINGS) begin
                receiver_settings_q <= SERIAL_WDATA;
            end else if (SERIAL_ADDR == `ADDR_INPUT_TERM_AB) begin
                input_termination_ab_q <= SERIAL_WDATA;
            end else if (SERIAL_ADDR == `ADDR_INPUT_TERM_CD) begin
                input_termination_cd_q <= SERIAL_WDATA;
            end else if (SERIAL_ADDR == `ADDR_EQUALIZER_AB) begin
                equalizer_ab_q <= SERIAL_WDATA;
            end else if (SERIAL_ADDR == `ADDR_EQUALIZER_CD) begin
                equalizer_cd_q <= SERIAL_WDATA;
            end else begin
                transmitter_settings_q <= SERIAL_WDATA;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            SERIAL_RDATA <= `REG_RESET_VALUE;
        end else if (SERIAL_READ) begin
            if (SERIAL_ADDR == `ADDR_HIGH_SPEED_MODES) begin
                SERIAL_RDATA <= high_speed_modes_q;
            end else if (SERIAL_ADDR == `ADDR_AUXILIARY_MODES) begin
                SERIAL_RDATA <= auxiliary_modes_q;
            end else if (SERIAL_ADDR == `ADDR_RECEIVER_SETTINGS) begin
                SERIAL_RDATA <= receiver_settings_q;
            end else if (SERIAL_ADDR == `ADDR_INPUT_TERM_AB) begin
                SERIAL_RDATA <= input_termination_ab_q;
            end else if (SERIAL_ADDR == `ADDR_INPUT_TERM_CD) begin
                SERIAL_RDATA <= input_termination_cd_q;
            end else if (SERIAL_ADDR == `ADDR_EQUALIZER_AB) begin
                SERIAL_RDATA <= equalizer_ab_q;
            end else if (SERIAL_ADDR == `ADDR_EQUALIZER_CD) begin
                SERIAL_RDATA <= equalizer_cd_q;
            end else begin
                SERIAL_RDATA <= transmitter_settings_q;
            end
        end
    end

    // analog controls registered from the register file
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            SERIAL_OWNED <= 1'h0;
            HIGHSPEED_ON <= 1'h0;
            HIGHSPEED_SOURCE <= 2'h0;
            AUX_ON <= 1'h0;
            AUX_COMMON_PORT_SOURCE <= 2'h0;
            INPUT_TERM_CONNECT <= 16'h0000;
            EQUALIZER_HIGH <= 16'h0000;
            PREEMPHASIS_LEVEL <= 2'h0;
            OUTPUT_TERM_ON <= 1'h0;
            OUTPUT_CURRENT_HIGH <= 1'h0;
        end else begin
            SERIAL_OWNED <= (owner_q == ST_SERIAL);
            HIGHSPEED_ON <= high_speed_modes_q[`MODES_ENABLE_BIT];
            HIGHSPEED_SOURCE <= high_speed_modes_q[`MODES_SELECT_LSB +: 2];
            AUX_ON <= auxiliary_modes_q[`MODES_ENABLE_BIT];
            AUX_COMMON_PORT_SOURCE <= auxiliary_modes_q[`MODES_SELECT_LSB +: 2];
            // receiver term select 0 opens every input switch
            INPUT_TERM_CONNECT <= receiver_settings_q[`RX_TERM_SELECT_BIT]
                ? {input_termination_cd_q, input_termination_ab_q}
                : 16'h0000;
            EQUALIZER_HIGH <= {equalizer_cd_q, equalizer_ab_q};
            PREEMPHASIS_LEVEL <= transmitter_settings_q[`TX_PREEMPH_LSB +: 2];
            OUTPUT_TERM_ON <= transmitter_settings_q[`TX_OUTTERM_BIT];
            OUTPUT_CURRENT_HIGH <= transmitter_settings_q[`TX_CURRENT_BIT];
        end
    end
endmodule

// file: design/strap_sync.sv
// three-stage synchroniser with agreement filter for the strap pins
`timescale 1ns/10ps
module strap_sync (
    input wire logic clk,
    input wire logic [7:0] pins,
    strap_if.sync_side straps
);
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] stable_q;

    // s1 feeds only s2; the filter looks at s2 and s3
    // no reset: the chain must fill during reset so the load edge sees real pins
    always_ff @(posedge clk) begin
        s1_q <= pins;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    // no reset: straps are static, so stable_q is caught from the pins even under reset
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                stable_q[i] <= s3_q[i];
            end
        end
    end

    assign straps.highspeed_enable = stable_q[0];
    assign straps.source_select = stable_q[2:1];
    assign straps.equalization_level = stable_q[3];
    assign straps.preemphasis_level = stable_q[5:4];
    assign straps.output_termination = stable_q[6];
    assign straps.output_current = stable_q[7];
endmodule

// file: pkg/strap_cfg.svh
// offsets, field positions and reset values of the strap configuration loader
`ifndef STRAP_CFG_SVH
`define STRAP_CFG_SVH
`define MODES_ENABLE_BIT 6
`define MODES_SELECT_LSB 0
`define AUX_ENABLE_VALUE 1'h1
`define RX_TERM_SELECT_BIT 0
`define TX_PREEMPH_LSB 2
`define TX_OUTTERM_BIT 1
`define TX_CURRENT_BIT 0
`define REG_RESET_VALUE 8'h00
`define TERM_PARALLEL_VALUE 8'h00
`define RX_PARALLEL_VALUE 8'h01
`define ADDR_HIGH_SPEED_MODES 3'h0
`define ADDR_AUXILIARY_MODES 3'h1
`define ADDR_RECEIVER_SETTINGS 3'h2
`define ADDR_INPUT_TERM_AB 3'h3
`define ADDR_INPUT_TERM_CD 3'h4
`define ADDR_EQUALIZER_AB 3'h5
`define ADDR_EQUALIZER_CD 3'h6
`define ADDR_TRANSMITTER 3'h7
`endif

// file: pkg/strap_if.sv
// synchronised strap levels passed from the synchroniser to the loader
`timescale 1ns/10ps
interface strap_if;
    logic highspeed_enable;
    logic [1:0] source_select;
    logic equalization_level;
    logic [1:0] preemphasis_level;
    logic output_termination;
    logic output_current;
    modport sync_side (
        output highspeed_enable,
        output source_select,
        output equalization_level,
        output preemphasis_level,
        output output_termination,
        output output_current
    );
    modport load_side (
        input highspeed_enable,
        input source_select,
        input equalization_level,
        input preemphasis_level,
        input output_termination,
        input output_current
    );
endinterface

// file: pkg/strap_pkg.sv
// types shared by the strap configuration loader
package strap_pkg;
    typedef logic [7:0] reg8_t;
    typedef logic [2:0] regaddr_t;
    typedef enum logic [1:0] {
        SRC_A,
        SRC_B,
        SRC_C,
        SRC_D
    } source_e;
    typedef enum {
        ST_RESET,
        ST_PARALLEL,
        ST_SERIAL
    } owner_e;
endpackage

// file: tb/parallel_strap_config_checker.sv
// port assertions for the strap configuration loader
`timescale 1ns/10ps
`include "strap_cfg.svh"
module parallel_strap_config_checker (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic SERIAL_WRITE,
    input wire logic SERIAL_READ,
    input wire logic [2:0] SERIAL_ADDR,
    input wire logic [7:0] SERIAL_RDATA,
    input wire logic SERIAL_OWNED,
    input wire logic HIGHSPEED_ON,
    input wire logic [1:0] HIGHSPEED_SOURCE,
    input wire logic AUX_ON,
    input wire logic [15:0] INPUT_TERM_CONNECT,
    input wire logic [15:0] EQUALIZER_HIGH,
    input wire logic [1:0] PREEMPHASIS_LEVEL,
    input wire logic OUTPUT_TERM_ON,
    input wire logic OUTPUT_CURRENT_HIGH
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    a_reset_clears: assert property (
        $fell(RST) |-> !HIGHSPEED_ON && !AUX_ON && !SERIAL_OWNED && EQUALIZER_HIGH == 16'h0)
        else $error("outputs not cleared by reset");
    a_aux_forced: assert property (
        $fell(RST) && !SERIAL_WRITE && !SERIAL_READ ##1 !SERIAL_WRITE && !SERIAL_READ
        |-> ##[1:2] AUX_ON) else $error("aux switch not enabled after load");
    a_terms_open: assert property (
        !SERIAL_OWNED |-> INPUT_TERM_CONNECT == 16'h0) else $error("termination connected");
    a_eq_uniform: assert property (
        !SERIAL_OWNED |-> EQUALIZER_HIGH == {16{EQUALIZER_HIGH[0]}})
        else $error("equalizer bits differ");
    a_owner_takes: assert property (
        SERIAL_WRITE || SERIAL_READ |-> ##[1:2] SERIAL_OWNED) else $error("owner not taken");
    a_owner_sticky: assert property (
        SERIAL_OWNED |=> SERIAL_OWNED) else $error("owner dropped without reset");
    a_straps_frozen: assert property (
        !SERIAL_OWNED && !SERIAL_WRITE && !$past(RST) && !$past(RST, 2) && !$past(RST, 3)
        |=> $stable(HIGHSPEED_SOURCE) && $stable(PREEMPHASIS_LEVEL) && $stable(HIGHSPEED_ON))
        else $error("outputs moved with straps");
    a_mode_readback: assert property (
        SERIAL_READ && !SERIAL_WRITE && SERIAL_ADDR == `ADDR_HIGH_SPEED_MODES |-> ##2
        SERIAL_RDATA[6] == HIGHSPEED_ON && SERIAL_RDATA[1:0] == HIGHSPEED_SOURCE)
        else $error("modes readback differs from outputs");
    a_tx_readback: assert property (
        SERIAL_READ && !SERIAL_WRITE && SERIAL_ADDR == `ADDR_TRANSMITTER |-> ##2
        SERIAL_RDATA[3:0] == {PREEMPHASIS_LEVEL, OUTPUT_TERM_ON, OUTPUT_CURRENT_HIGH})
        else $error("transmitter readback differs from outputs");
endmodule

// file: tb/parallel_strap_config_test.sv
// self-checking bench for the strap configuration loader
`timescale 1ns/10ps
module parallel_strap_config_test
    import strap_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] straps;
    logic wr, rd, owned, hs_on, aux_on, oto, ocl;
    logic [2:0] addr;
    logic [1:0] hs_src, aux_src, pe;
    logic [15:0] term, eq;
    reg8_t wdata, rdata, s;
    reg8_t model [8];
    logic [31:0] lfsr_q = 32'h4219;
    int errors = 0;
    int total_checks = 0;
    always #10 clk = ~clk;
    strap_host u_strap_host (.clk(clk), .straps(straps), .wr(wr), .rd(rd), .addr(addr),
        .wdata(wdata));
    parallel_strap_config u_parallel_strap_config (.CORE_CLK(clk), .RST(rst),
        .STRAP_HIGHSPEED_ENABLE(straps[0]), .STRAP_SOURCE_SELECT(straps[2:1]),
        .STRAP_EQUALIZATION_LEVEL(straps[3]), .STRAP_PREEMPHASIS_LEVEL(straps[5:4]),
        .STRAP_OUTPUT_TERMINATION(straps[6]), .STRAP_OUTPUT_CURRENT(straps[7]),
        .SERIAL_WRITE(wr), .SERIAL_READ(rd), .SERIAL_ADDR(addr), .SERIAL_WDATA(wdata),
        .SERIAL_RDATA(rdata), .SERIAL_OWNED(owned), .HIGHSPEED_ON(hs_on),
        .HIGHSPEED_SOURCE(hs_src), .AUX_ON(aux_on), .AUX_COMMON_PORT_SOURCE(aux_src),
        .INPUT_TERM_CONNECT(term), .EQUALIZER_HIGH(eq), .PREEMPHASIS_LEVEL(pe),
        .OUTPUT_TERM_ON(oto), .OUTPUT_CURRENT_HIGH(ocl));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic load_model(input reg8_t v);
        model[0] = {1'b0, v[0], 4'h0, v[2:1]};
        model[1] = {2'b01, 4'h0, v[2:1]};
        model[2] = 8'h01;
        model[3] = 8'h00;
        model[4] = 8'h00;
        model[5] = {8{v[3]}};
        model[6] = {8{v[3]}};
        model[7] = {4'h0, v[5:4], v[6], v[7]};
    endtask
    task automatic check_outputs;
        check(hs_on, model[0][6]);
        check(hs_src, model[0][1:0]);
        check(aux_src, model[1][1:0]);
        check(aux_on, model[1][6]);
        check(term, {model[4], model[3]} & {16{model[2][0]}});
        check(eq, {model[6], model[5]});
        check(pe, model[7][3:2]);
        check(oto, model[7][1]);
        check(ocl, model[7][0]);
    endtask
    task automatic read_check(input logic [2:0] a);
        u_strap_host.access(1'b0, a, 8'h00);
        @(posedge clk);
        #1;
        check(rdata, model[a]);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            s = {lfsr_q[7:6], i[2:1], lfsr_q[3], i[1:0], lfsr_q[0]};
            @(posedge clk);
            rst <= 1'b1;
            u_strap_host.set_straps(s);
            repeat (12) @(posedge clk);
            rst <= 1'b0;
            load_model(s);
            repeat (4) @(posedge clk);
            #1;
            check(owned, 1'b0);
            check_outputs;
            // moved straps must not leak through without a reset
            u_strap_host.set_straps(~s);
            repeat (6) @(posedge clk);
            #1;
            check_outputs;
            for (int a = 0; a < 8; a++) read_check(a[2:0]);
            check(owned, 1'b1);
            if (i[0]) begin
                lfsr_q = lfsr_next(lfsr_q);
                u_strap_host.access(1'b1, 3'h3, lfsr_q[7:0]);
                model[3] = lfsr_q[7:0];
                u_strap_host.access(1'b1, lfsr_q[10:8], lfsr_q[23:16]);
                model[lfsr_q[10:8]] = lfsr_q[23:16];
                repeat (3) @(posedge clk);
                #1;
                check_outputs;
                read_check(lfsr_q[10:8]);
            end
        end
        wrap_up;
    end
    initial begin
        #100000;
        errors++;
        wrap_up;
    end
endmodule
bind parallel_strap_config parallel_strap_config_checker u_parallel_strap_config_checker (.*);

// file: tb/strap_host.sv
// board strap levels and a serial host for the strap configuration loader
`timescale 1ns/10ps
module strap_host (
    input wire logic clk,
    output logic [7:0] straps,
    output logic wr,
    output logic rd,
    output logic [2:0] addr,
    output logic [7:0] wdata
);
    initial begin
        straps = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
    end
    // straps are static; a new set only takes effect through a reset
    task automatic set_straps(input logic [7:0] v);
        @(posedge clk);
        straps <= v;
    endtask
    // one-cycle pulse; idle bus shows inverted values so stale data is never trusted
    task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
endmodule
